// >>> rtl/fgr_guard.sv
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Part identity byte reads back from fixed flash location 0x3ffe.
// - Write or erase with monitor or its reset enable off forces fault reset.
// - Power-on reset turns on supply monitor and its reset-source enable.
// - Interrupts raised during flash operation wait until it completes.
// - Idle mode ends within three clocks of a wake event.
// - Sense amplifiers enabled only on the cycle after each flash access.
// - One-shot active after reset; bypass bit six disables it.
// - Flash rows are 64 bytes; row-crossing reads are counted.
// - Fault reset sets the flash fault flag in reset-source register.
// - Two ordered key bytes arm one operation; wrong keys lock until reset.
module fgr_guard #(
  parameter logic [7:0] PART_ID = 8'h5a // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic flash_error_reset,
  output logic cpu_halt,
  output logic sense_amp_en
);
  import fgr_pkg::*;

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_have, w_have, rd_pend, rd_wait;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic psc_we, psc_ee, bypass, mon_en, mon_rst_en;
  logic por_flag, fault_flag, idle_reg;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set, irq_clr;
  logic [FL_AW-1:0] flash_addr;
  logic [15:0] row_cnt;
  logic [ROW_W-1:0] last_row;
  logic row_valid;
  fgr_key_t key_state, key_next;
  fgr_fl_t fl_state;
  logic [PAGE_CW-1:0] erase_cnt;
  logic irq_reg, fault_rst_reg, halt_reg, sa_reg;
  fgr_mem_req_t mem_req;
  logic [7:0] mem_rdata;
  logic wr_go, wr_lane, flash_req, guard_ok, fault_hit, op_go, op_write;
  logic rd_issue, mem_access, erase_last, row_cross, pending;
  logic [31:0] rd_word;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign flash_error_reset = fault_rst_reg;
  assign cpu_halt = halt_reg;
  assign sense_amp_en = sa_reg;

  // Write commit needs both channels and an idle flash engine
  assign wr_go = aw_have && w_have && !bvalid_reg && fl_state == FL_IDLE;
  assign wr_lane = wr_go && w_strb_q[0];
  assign flash_req = wr_lane && aw_addr_q == OFF_DATA && psc_we;
  assign guard_ok = mon_en && mon_rst_en;
  assign fault_hit = flash_req && !guard_ok;
  assign op_go = flash_req && guard_ok && key_state == KEY_OPEN;
  assign op_write = op_go && !psc_ee;
  assign erase_last = fl_state == FL_ERASE && erase_cnt == PAGE_LAST;
  assign rd_issue = rd_pend && fl_state == FL_IDLE && !op_go;
  assign mem_access = mem_req.we || mem_req.re;
  assign row_cross = rd_issue && row_valid && fgr_row_of(flash_addr) != last_row;
  assign pending = |(irq_stat & irq_mask);

  fgr_flash_array #(.PART_ID(PART_ID)) u_array (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_have <= 1'b0;
      aw_addr_q <= 8'h00;
    end else begin
      awready_reg <= awvalid && !awready_reg && !aw_have;
      if (awvalid && awready_reg) begin
        aw_have <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_have <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      wready_reg <= wvalid && !wready_reg && !w_have;
      if (wvalid && wready_reg) begin
        w_have <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= fgr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read decode of the register map
  always_comb begin
    rd_word = 32'h0000_0000;
    if (araddr == OFF_PSC) begin
      rd_word[PSC_WE_BIT] = psc_we;
      rd_word[PSC_EE_BIT] = psc_ee;
    end else if (araddr == OFF_KEY) begin
      rd_word[1:0] = key_state;
    end else if (araddr == OFF_SCALE) begin
      rd_word[SCALE_BYPASS_BIT] = bypass;
    end else if (araddr == OFF_RSRC) begin
      rd_word[RS_POR_BIT] = por_flag;
      rd_word[RS_MON_BIT] = mon_rst_en;
      rd_word[RS_FAULT_BIT] = fault_flag;
    end else if (araddr == OFF_SMC) begin
      rd_word[SMC_EN_BIT] = mon_en;
    end else if (araddr == OFF_ADDR) begin
      rd_word[FL_AW-1:0] = flash_addr;
    end else if (araddr == OFF_ROWS) begin
      rd_word[15:0] = row_cnt;
    end else if (araddr == OFF_ISTAT) begin
      rd_word[IRQ_W-1:0] = irq_stat;
    end else if (araddr == OFF_IMASK) begin
      rd_word[IRQ_W-1:0] = irq_mask;
    end else if (araddr == OFF_PWR) begin
      rd_word[PWR_IDLE_BIT] = idle_reg;
      rd_word[PWR_BUSY_BIT] = fl_state != FL_IDLE;
    end
  end

  // Read channel; data port waits one cycle on the array
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      rd_pend <= 1'b0;
      rd_wait <= 1'b0;
    end else begin
      arready_reg <= arvalid && !arready_reg && !rd_pend && !rd_wait && !rvalid_reg;
      if (arvalid && arready_reg) begin
        if (araddr == OFF_DATA) begin
          rd_pend <= 1'b1;
        end else begin
          rvalid_reg <= 1'b1;
          rdata_reg <= rd_word;
          rresp_reg <= fgr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
      end else if (rd_issue) begin
        rd_pend <= 1'b0;
        rd_wait <= 1'b1;
      end else if (rd_wait) begin
        rd_wait <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h00_0000, mem_rdata};
        rresp_reg <= RESP_OKAY;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Software controls; a fault reset clears the program-store bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_we <= 1'b0;
      psc_ee <= 1'b0;
      bypass <= RST_BYPASS;
      mon_en <= RST_MON_EN;
      mon_rst_en <= RST_MON_RST;
      flash_addr <= '0;
      irq_mask <= '0;
    end else if (fault_hit) begin
      psc_we <= 1'b0;
      psc_ee <= 1'b0;
    end else if (wr_lane) begin
      if (aw_addr_q == OFF_PSC) begin
        psc_we <= w_data_q[PSC_WE_BIT];
        psc_ee <= w_data_q[PSC_EE_BIT];
      end else if (aw_addr_q == OFF_SCALE) begin
        bypass <= w_data_q[SCALE_BYPASS_BIT];
      end else if (aw_addr_q == OFF_RSRC) begin
        mon_rst_en <= w_data_q[RS_MON_BIT];
      end else if (aw_addr_q == OFF_SMC) begin
        mon_en <= w_data_q[SMC_EN_BIT];
      end else if (aw_addr_q == OFF_ADDR) begin
        flash_addr <= w_data_q[FL_AW-1:0];
      end else if (aw_addr_q == OFF_IMASK) begin
        irq_mask <= w_data_q[IRQ_W-1:0];
      end
    end
  end

  // Reset cause flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_flag <= 1'b1;
      fault_flag <= 1'b0;
      fault_rst_reg <= 1'b0;
    end else begin
      fault_rst_reg <= fault_hit;
      if (fault_hit) begin
        por_flag <= 1'b0;
        fault_flag <= 1'b1;
      end
    end
  end

  // Lock and key sequence
  always_comb begin
    key_next = key_state;
    if (fault_hit) begin
      key_next = KEY_IDLE;
    end else if (flash_req) begin
      key_next = (key_state == KEY_OPEN) ? KEY_IDLE : KEY_LOCKED;
    end else if (wr_lane && aw_addr_q == OFF_KEY) begin
      case (key_state)
        KEY_IDLE: key_next = (w_data_q[7:0] == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
        KEY_HALF: key_next = (w_data_q[7:0] == KEY_SECOND) ? KEY_OPEN : KEY_LOCKED;
        default: key_next = KEY_LOCKED;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_state <= KEY_IDLE;
    end else begin
      key_state <= key_next;
    end
  end

  // Page erase walks every byte of the page
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_state <= FL_IDLE;
      erase_cnt <= '0;
    end else begin
      case (fl_state)
        FL_IDLE: begin
          if (op_go && psc_ee) begin
            fl_state <= FL_ERASE;
            erase_cnt <= '0;
          end
        end
        FL_ERASE: begin
          erase_cnt <= erase_cnt + 1'b1;
          if (erase_last) begin
            fl_state <= FL_IDLE;
          end
        end
        default: fl_state <= FL_IDLE;
      endcase
    end
  end

  always_comb begin
    mem_req = '0;
    if (fl_state == FL_ERASE) begin
      mem_req.we = 1'b1;
      mem_req.erase = 1'b1;
      mem_req.addr = {flash_addr[FL_AW-1:PAGE_SHIFT], erase_cnt};
    end else if (op_write) begin
      mem_req.we = 1'b1;
      mem_req.addr = flash_addr;
      mem_req.wdata = w_data_q[7:0];
    end else if (rd_issue) begin
      mem_req.re = 1'b1;
      mem_req.addr = flash_addr;
    end
  end

  // Event status, set wins over write-one-to-clear
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE_BIT] = op_write || erase_last;
    irq_set[IRQ_LOCK_BIT] = key_state != KEY_LOCKED && key_next == KEY_LOCKED;
    irq_set[IRQ_ROW_BIT] = row_cross;
    irq_clr = (wr_lane && aw_addr_q == OFF_ISTAT) ? w_data_q[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq_reg <= pending && fl_state == FL_IDLE;
    end
  end

  // Idle mode, left on any unmasked pending event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= idle_reg;
      if (fault_hit || pending) begin
        idle_reg <= 1'b0;
      end else if (wr_lane && aw_addr_q == OFF_PWR) begin
        idle_reg <= w_data_q[PWR_IDLE_BIT];
      end
    end
  end

  // Row tracking of array reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_cnt <= 16'h0000;
      last_row <= '0;
      row_valid <= 1'b0;
    end else if (rd_issue) begin
      last_row <= fgr_row_of(flash_addr);
      row_valid <= 1'b1;
      if (row_cross) begin
        row_cnt <= row_cnt + 16'h0001;
      end
    end
  end

  // Sense amps pulse per access unless bypassed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa_reg <= 1'b0;
    end else begin
      sa_reg <= bypass || mem_access;
    end
  end

  a_guard_fault_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    flash_req && !(mon_en && mon_rst_en) |=> flash_error_reset && fault_flag && !por_flag)
    else $error("Guard violation did not raise fault reset");
  a_fault_no_change: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_hit |-> !mem_req.we ##1 (fl_state == FL_IDLE && key_state == KEY_IDLE))
    else $error("Flash modified on guarded request");
  a_por_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> mon_en && mon_rst_en && por_flag && !fault_flag)
    else $error("Supply monitor not on after reset");
  a_irq_held_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    fl_state == FL_ERASE |=> !irq)
    else $error("Interrupt raised during flash operation");
  a_idle_wake_time: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_halt && pending |-> ##[1:3] !cpu_halt)
    else $error("Idle wake took more than three cycles");
  a_oneshot_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !bypass && !mem_access |=> !sense_amp_en)
    else $error("Sense amps on without flash access");
  a_bypass_static: assert property (@(posedge aclk) disable iff (!aresetn)
    bypass [*2] |-> sense_amp_en)
    else $error("Bypass did not hold sense amps on");
  a_key_lock_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    key_state == KEY_LOCKED && !fault_hit |=> key_state == KEY_LOCKED && !mem_req.we)
    else $error("Key lock released without reset");
  a_row_count: assert property (@(posedge aclk) disable iff (!aresetn)
    row_cross |=> row_cnt == $past(row_cnt) + 16'h0001 && irq_stat[IRQ_ROW_BIT])
    else $error("Row crossing not counted");
  a_part_id_read: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_req.re && mem_req.addr == ID_ADDR |=> mem_rdata == PART_ID)
    else $error("Identity byte read wrong");
endmodule : fgr_guard
`default_nettype wire

// >>> common/fgr_pkg.sv
`default_nettype none
package fgr_pkg;
  // Flash array geometry
  localparam int FL_AW = 14;
  localparam int FLASH_BYTES = 16384;
  localparam int PAGE_BYTES = 512;
  localparam int ROW_BYTES = 64;
  localparam int PAGE_SHIFT = $clog2(PAGE_BYTES);
  localparam int ROW_SHIFT = $clog2(ROW_BYTES);
  localparam int PAGE_CW = PAGE_SHIFT;
  localparam int ROW_W = FL_AW - ROW_SHIFT;
  localparam logic [PAGE_CW-1:0] PAGE_LAST = 9'h1ff;
  localparam logic [FL_AW-1:0] ID_ADDR = 14'h3ffe;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Key sequence
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  // Register byte offsets
  localparam logic [7:0] OFF_PSC = 8'h00;
  localparam logic [7:0] OFF_KEY = 8'h04;
  localparam logic [7:0] OFF_SCALE = 8'h08;
  localparam logic [7:0] OFF_RSRC = 8'h0c;
  localparam logic [7:0] OFF_SMC = 8'h10;
  localparam logic [7:0] OFF_ADDR = 8'h14;
  localparam logic [7:0] OFF_DATA = 8'h18;
  localparam logic [7:0] OFF_ROWS = 8'h1c;
  localparam logic [7:0] OFF_ISTAT = 8'h20;
  localparam logic [7:0] OFF_IMASK = 8'h24;
  localparam logic [7:0] OFF_PWR = 8'h28;
  // Field positions
  localparam int PSC_WE_BIT = 0;
  localparam int PSC_EE_BIT = 1;
  localparam int SCALE_BYPASS_BIT = 6;
  localparam int RS_POR_BIT = 0;
  localparam int RS_MON_BIT = 1;
  localparam int RS_FAULT_BIT = 6;
  localparam int SMC_EN_BIT = 7;
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_BUSY_BIT = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LOCK_BIT = 1;
  localparam int IRQ_ROW_BIT = 2;
  // Reset values
  localparam logic RST_MON_EN = 1'b1;
  localparam logic RST_MON_RST = 1'b1;
  localparam logic RST_BYPASS = 1'b0;
  // Timing
  localparam int WAKE_MAX_CYC = 3;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN, KEY_LOCKED} fgr_key_t;
  typedef enum logic {FL_IDLE, FL_ERASE} fgr_fl_t;

  typedef struct packed {
    logic we;
    logic erase;
    logic re;
    logic [FL_AW-1:0] addr;
    logic [7:0] wdata;
  } fgr_mem_req_t;

  function automatic logic [ROW_W-1:0] fgr_row_of(input logic [FL_AW-1:0] a);
    return a[FL_AW-1:ROW_SHIFT];
  endfunction : fgr_row_of

  function automatic logic fgr_mapped(input logic [7:0] off);
    return off == OFF_PSC || off == OFF_KEY || off == OFF_SCALE || off == OFF_RSRC ||
      off == OFF_SMC || off == OFF_ADDR || off == OFF_DATA || off == OFF_ROWS ||
      off == OFF_ISTAT || off == OFF_IMASK || off == OFF_PWR;
  endfunction : fgr_mapped
endpackage : fgr_pkg
`default_nettype wire

// >>> rtl/fgr_flash_array.sv
`timescale 1ns/1ps
`default_nettype none
module fgr_flash_array #(
  parameter logic [7:0] PART_ID = 8'h5a
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fgr_pkg::fgr_mem_req_t req,
  output logic [7:0] rdata
);
  import fgr_pkg::*;

  logic [7:0] mem [FLASH_BYTES];

  // Programming only clears bits; erase sets the byte
  always_ff @(posedge aclk) begin
    if (req.we) begin
      mem[req.addr] <= req.erase ? ERASED_BYTE : (mem[req.addr] & req.wdata);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 8'h00;
    end else if (req.re) begin
      rdata <= (req.addr == ID_ADDR) ? PART_ID : mem[req.addr];
    end
  end
endmodule : fgr_flash_array
`default_nettype wire

// >>> sim/fgr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fgr_core_model (
  input wire logic aclk,
  output var logic [7:0] awaddr,
  output var logic awvalid,
  input wire logic awready,
  output var logic [31:0] wdata,
  output var logic [3:0] wstrb,
  output var logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output var logic bready,
  output var logic [7:0] araddr,
  output var logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output var logic rready
);
  import fgr_pkg::*;
  int hangs = 0;

  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h1;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Released lines show the inverse of the last value
  // Handshakes read mid-cycle, settled values of the coming edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      n++;
      if (aw_hs) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_hs) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!b_hs && n < 3000);
    bready <= 1'b0;
    if (n >= 3000) hangs++;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      n++;
      if (ar_hs) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!r_hs && n < 3000);
    rready <= 1'b0;
    if (n >= 3000) hangs++;
    @(posedge aclk);
  endtask : rd

  // Firmware flash routine; guard re-arms the supply monitor first
  task automatic flash_op(input logic [13:0] a, input logic [7:0] d, input logic er,
      input logic guard);
    logic [1:0] r;
    if (32'(a) >= FLASH_BYTES) return;
    // Bench clock stands for the internal oscillator here
    // Interrupt mask is left as the caller set it
    wr(OFF_PSC, {30'h0, er, 1'b1}, r);
    if (guard) begin
      wr(OFF_SMC, 32'h80, r);
      wr(OFF_RSRC, 32'h03, r);
    end
    wr(OFF_ADDR, {18'h0, a}, r);
    wr(OFF_KEY, {24'h0, KEY_FIRST}, r);
    wr(OFF_KEY, {24'h0, KEY_SECOND}, r);
    wr(OFF_DATA, {24'h0, d}, r);
    wr(OFF_PSC, 32'h0, r);
  endtask : flash_op
endmodule : fgr_core_model
`default_nettype wire

// >>> sim/test_flash_guard_and_read_power.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_guard_and_read_power;
  import fgr_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identity value
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, flash_error_reset, cpu_halt, sense_amp_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, c;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int n_fail = 0, checked = 0, n_frst = 0, sa_cnt = 0, irq_cnt = 0, s, f;

  fgr_guard #(.PART_ID(ID_VAL)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq, .flash_error_reset, .cpu_halt, .sense_amp_en);
  fgr_core_model core (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Cycle counts of the pulse and level outputs
  always @(negedge aclk) begin
    if (flash_error_reset === 1'b1) n_frst <= n_frst + 1;
    if (sense_amp_en === 1'b1) sa_cnt <= sa_cnt + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] v;
    logic [1:0] q;
    core.rd(a, v, q);
    chk(v, e, m);
    chk({30'h0, q}, 32'(RESP_OKAY), m);
  endtask : rchk

  task automatic done_test(input string m);
    $display("test %s finished", m);
  endtask : done_test

  task automatic report_and_stop;
    n_fail = n_fail + core.hangs;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    report_and_stop;
  end

  initial begin
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFF_RSRC, 32'h03, "reset source");
    rchk(OFF_SMC, 32'h80, "monitor enable");
    rchk(OFF_SCALE, 32'h00, "scale reset");
    s = sa_cnt;
    repeat (8) @(posedge aclk);
    chk(sa_cnt - s, 0, "amp idle");
    done_test("reset values");
    core.wr(OFF_ADDR, 32'(ID_ADDR), r);
    s = sa_cnt;
    rchk(OFF_DATA, 32'(ID_VAL), "part id");
    chk(sa_cnt - s, 1, "amp pulse");
    core.wr(OFF_SCALE, 32'h40, r);
    s = sa_cnt;
    repeat (8) @(posedge aclk);
    chk(sa_cnt - s, 8, "bypass on");
    core.wr(OFF_SCALE, 32'h00, r);
    s = sa_cnt;
    repeat (8) @(posedge aclk);
    chk(sa_cnt - s, 0, "bypass off");
    done_test("id and one-shot");
    core.wr(OFF_ADDR, 32'h3f, r);
    core.rd(OFF_DATA, d, r);
    core.rd(OFF_ROWS, c, r);
    core.wr(OFF_ADDR, 32'h40, r);
    core.rd(OFF_DATA, d, r);
    core.rd(OFF_DATA, d, r);
    rchk(OFF_ROWS, c + 1, "row count");
    rchk(OFF_ISTAT, 32'h4, "row status");
    core.wr(OFF_IMASK, 32'h5, r);
    chk({31'h0, irq}, 1, "irq row");
    s = irq_cnt;
    core.flash_op(14'h0040, 8'h00, 1'b1, 1'b1);
    chk(32'(irq_cnt - s < 200), 1, "irq held in erase");
    chk({31'h0, irq}, 1, "irq after erase");
    rchk(OFF_DATA, 32'hff, "erased");
    core.flash_op(14'h0040, 8'h5a, 1'b0, 1'b1);
    rchk(OFF_DATA, 32'h5a, "written");
    rchk(OFF_ISTAT, 32'h5, "done status");
    core.wr(OFF_ISTAT, 32'h7, r);
    rchk(OFF_ISTAT, 32'h0, "status cleared");
    chk({31'h0, irq}, 0, "irq cleared");
    done_test("erase and write");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) core.wr(OFF_SMC, 32'h00, r);
      else core.wr(OFF_RSRC, 32'h01, r);
      f = n_frst;
      core.flash_op(14'h0040, 8'h00, 1'b0, 1'b0);
      chk(n_frst - f, 1, "fault reset");
      rchk(OFF_RSRC, k ? 32'h40 : 32'h42, "fault flag");
      rchk(OFF_DATA, 32'h5a, "no change");
      core.wr(OFF_SMC, 32'h80, r);
    end
    core.wr(OFF_RSRC, 32'h03, r);
    done_test("guard");
    core.wr(OFF_ISTAT, 32'h7, r);
    core.wr(OFF_IMASK, 32'h2, r);
    core.wr(OFF_PWR, 32'h1, r);
    chk({31'h0, cpu_halt}, 1, "halted");
    core.wr(OFF_KEY, 32'h11, r);
    @(posedge aclk);
    chk({31'h0, cpu_halt}, 0, "woken");
    rchk(OFF_PWR, 32'h0, "idle bit");
    rchk(OFF_KEY, 32'h3, "key locked");
    core.flash_op(14'h0040, 8'h00, 1'b0, 1'b1);
    rchk(OFF_DATA, 32'h5a, "locked no write");
    chk({31'h0, irq}, 1, "irq lock");
    core.wr(OFF_IMASK, 32'h0, r);
    chk({31'h0, irq}, 0, "irq masked");
    done_test("idle and lock");
    core.wr(8'h30, 32'h1, r);
    chk({30'h0, r}, 32'(RESP_SLVERR), "unmapped write");
    core.rd(8'h2c, d, r);
    chk({30'h0, r}, 32'(RESP_SLVERR), "unmapped read");
    chk(d, 32'h0, "unmapped data");
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFF_KEY, 32'h0, "key after reset");
    rchk(OFF_RSRC, 32'h03, "monitor after reset");
    done_test("unmapped and reset");
    report_and_stop;
  end
endmodule : test_flash_guard_and_read_power
`default_nettype wire
